// ---- logic/pao_pkg.sv ----
package pao_pkg;
  // Word width and pipeline depth
  localparam int SAMPLE_W = 10;
  localparam int LATENCY = 5;
  localparam int WAKE_CYCLES = 5;
  localparam int FIFO_DEPTH = 8;
  // Straight offset binary landmarks
  localparam logic [SAMPLE_W-1:0] CODE_NEG_FS = 10'h000;
  localparam logic [SAMPLE_W-1:0] CODE_MID = 10'h200;
  localparam logic [SAMPLE_W-1:0] CODE_POS_FS = 10'h3ff;
  localparam logic [SAMPLE_W-1:0] SIGN_FLIP = 10'h200;
  localparam logic [SAMPLE_W-1:0] DATA_RESET = 10'h000;
  localparam logic [2:0] CNT_ZERO = 3'h0;
  localparam logic [2:0] CNT_ONE = 3'h1;
  localparam logic [2:0] WAKE_LOAD = 3'h5;
  localparam logic [3:0] LAT_ZERO = 4'h0;
  localparam logic [3:0] LAT_ONE = 4'h1;
  localparam logic [3:0] LAT_FULL = 4'h5;
  typedef enum logic [2:0] {
    PAO_OFF = 3'b001,
    PAO_WAKE = 3'b010,
    PAO_RUN = 3'b100
  } pao_state_t;
endpackage

// ---- logic/pao_stream_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface pao_stream_if #(parameter int W = 10);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ---- logic/pao_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module pao_fifo #(
  parameter int W = 10,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic ce,
  input wire logic clr,
  pao_stream_if.snk in_s,
  pao_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  assign in_s.ready = (count != (AW+1)'(DEPTH));
  assign out_s.valid = (count != '0);
  assign out_s.data = mem[rd_ptr];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;

  always_comb
  begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push)
    begin
      next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop)
    begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop)
    begin
      next_count = count + 1'b1;
    end
    else if (pop && !push)
    begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (clr)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else if (ce)
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      if (push)
      begin
        mem[wr_ptr] <= in_s.data;
      end
    end
  end
endmodule // pao_fifo
`default_nettype wire

// ---- logic/pao_pipe.sv ----
`timescale 1ns/1ps
`default_nettype none
module pao_pipe #(
  parameter int W = 10,
  parameter int DEPTH = 5
) (
  input wire logic clk,
  input wire logic ce,
  input wire logic adv,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] stage [DEPTH];
  logic [W-1:0] next_stage [DEPTH];

  // One word per stage, all stages advance together
  always_comb
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      next_stage[i] = stage[i];
    end
    if (adv)
    begin
      next_stage[0] = din;
      for (int i = 1; i < DEPTH; i++)
      begin
        next_stage[i] = stage[i-1];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : g_stage
      always_ff @(posedge clk)
      begin
        if (ce)
        begin
          stage[g] <= next_stage[g];
        end
      end
    end
  endgenerate

  assign dout = stage[DEPTH-1];
endmodule // pao_pipe
`default_nettype wire

// ---- logic/pao_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module pao_top
#(
  parameter int W = pao_pkg::SAMPLE_W,
  parameter int DEPTH = pao_pkg::LATENCY
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [pao_pkg::SAMPLE_W-1:0] sample_twos,
  input wire logic output_enable_n,
  input wire logic power_down,
  output logic [pao_pkg::SAMPLE_W-1:0] data_out,
  output logic [pao_pkg::SAMPLE_W-1:0] data_oe,
  output logic data_valid,
  output logic fifo_valid,
  output logic [pao_pkg::SAMPLE_W-1:0] fifo_data,
  input wire logic fifo_ready,
  output logic fifo_overflow
);
  import pao_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Coding: the quantizer result arrives in two's complement; flipping the
  // MSB gives straight offset binary, which is monotonic over the full range

  logic [SAMPLE_W-1:0] coded;
  assign coded = sample_twos ^ SIGN_FLIP;

  ////////////////////////////////////////////////////////////////////////////
  // Fixed latency pipeline

  logic [SAMPLE_W-1:0] pipe_out;
  pao_pipe #(
    .W(SAMPLE_W),
    .DEPTH(DEPTH)
  ) u_pipe (
    .clk(clk),
    .ce(ce),
    .adv(1'b1),
    .din(coded),
    .dout(pipe_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Power state: the pipeline holds junk from power-down, so the first
  // words after exit are flagged invalid rather than cleared

  pao_state_t state, next_state;
  logic [2:0] wake_cnt, next_wake_cnt;
  // Power-down returning mid-count sends the machine back to the start

  always_comb
  begin
    next_state = state;
    next_wake_cnt = wake_cnt;
    case (state)
      PAO_OFF:
      begin
        if (!power_down)
        begin
          next_state = PAO_WAKE;
          next_wake_cnt = WAKE_LOAD;
        end
      end
      PAO_WAKE:
      begin
        if (power_down)
        begin
          next_state = PAO_OFF;
        end
        else if (wake_cnt == CNT_ONE)
        begin
          next_state = PAO_RUN;
          next_wake_cnt = CNT_ZERO;
        end
        else
        begin
          next_wake_cnt = wake_cnt - 3'h1;
        end
      end
      PAO_RUN:
      begin
        if (power_down)
        begin
          next_state = PAO_OFF;
        end
      end
      default:
      begin
        next_state = PAO_OFF;
        next_wake_cnt = CNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state <= PAO_OFF;
      wake_cnt <= CNT_ZERO;
    end
    else if (ce)
    begin
      state <= next_state;
      wake_cnt <= next_wake_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output stage, every port from a flip-flop

  logic next_drive;
  logic next_valid;
  logic [SAMPLE_W-1:0] next_data;
  logic fifo_in_ready;
  logic next_overflow;

  always_comb
  begin
    next_drive = !output_enable_n && !power_down;
    next_valid = (next_state == PAO_RUN);
    // Words from the power-down period are never shown as valid data
    next_data = pipe_out;
    next_overflow = fifo_overflow;
    // The buffer is fed from the registered word, so loss is judged there
    if (data_valid && !fifo_in_ready)
    begin
      next_overflow = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      data_out <= DATA_RESET;
      data_oe <= '0;
      data_valid <= 1'b0;
      fifo_overflow <= 1'b0;
    end
    else if (ce)
    begin
      data_out <= next_data;
      data_oe <= {SAMPLE_W{next_drive}};
      data_valid <= next_valid;
      fifo_overflow <= next_overflow;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture buffer: the converter cannot stall, so a full buffer drops the
  // word and raises a sticky overflow flag

  pao_stream_if #(.W(SAMPLE_W)) fin ();
  pao_stream_if #(.W(SAMPLE_W)) fout ();
  assign fin.valid = data_valid;
  assign fin.data = data_out;
  assign fifo_in_ready = fin.ready;

  pao_fifo #(
    .W(SAMPLE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .ce(ce),
    .clr(sys_rst),
    .in_s(fin.snk),
    .out_s(fout.src)
  );

  logic [SAMPLE_W-1:0] next_fifo_data;
  logic next_fifo_valid;
  logic fifo_take;
  // Registered skid of one word so the port comes from a flip-flop
  assign fifo_take = fout.valid && (!fifo_valid || fifo_ready);
  assign fout.ready = fifo_take;

  always_comb
  begin
    next_fifo_valid = fifo_valid;
    next_fifo_data = fifo_data;
    if (fifo_valid && fifo_ready)
    begin
      next_fifo_valid = 1'b0;
    end
    if (fifo_take)
    begin
      next_fifo_valid = 1'b1;
      next_fifo_data = fout.data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      fifo_valid <= 1'b0;
      fifo_data <= DATA_RESET;
    end
    else if (ce)
    begin
      fifo_valid <= next_fifo_valid;
      fifo_data <= next_fifo_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [3:0] lat_cnt, next_lat_cnt;

  // Counts enabled edges after reset, so the latency check only starts once
  // the pipeline holds words taken after reset
  always_comb
  begin
    next_lat_cnt = lat_cnt;
    if (lat_cnt != LAT_FULL)
    begin
      next_lat_cnt = lat_cnt + LAT_ONE;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      lat_cnt <= LAT_ZERO;
    end
    else if (ce)
    begin
      lat_cnt <= next_lat_cnt;
    end
  end

  // Power-down exit: the first enabled edge that sees power-down low
  sequence wake_s;
    ce && state == PAO_OFF && !power_down;
  endsequence

  // Last step of the exit count
  sequence wake_last_s;
    ce && state == PAO_WAKE && wake_cnt == CNT_ONE && !power_down;
  endsequence

  oe_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && output_enable_n) |=> data_oe == '0)
    else $error("drivers on while output enable high");
  oe_on_a: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && !output_enable_n && !power_down) |=> data_oe == '1)
    else $error("drivers off while enabled");
  pd_hiz_a: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && power_down) |=> (data_oe == '0 && !data_valid))
    else $error("drivers on in power-down");
  pd_enter_a: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && power_down) |=> state == PAO_OFF)
    else $error("power-down not entered");
  wake_gap_a: assert property (@(posedge clk) disable iff (sys_rst)
    wake_s |=> !data_valid [*5])
    else $error("valid too early after wake");
  wake_end_a: assert property (@(posedge clk) disable iff (sys_rst)
    wake_last_s |=> data_valid)
    else $error("valid not raised after wake");
  run_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && state == PAO_RUN && !power_down) |=> data_valid)
    else $error("valid dropped while running");
  code_mid_a: assert property (@(posedge clk) disable iff (sys_rst)
    (sample_twos == CODE_NEG_FS) |-> coded == CODE_MID)
    else $error("mid scale code wrong");
  code_fs_a: assert property (@(posedge clk) disable iff (sys_rst)
    (sample_twos == ~SIGN_FLIP) |-> coded == CODE_POS_FS)
    else $error("full scale code wrong");
  latency_a: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && lat_cnt == LAT_FULL && $past(ce, 1) && $past(ce, 2) &&
     $past(ce, 3) && $past(ce, 4) && $past(ce, 5))
    |=> data_out == $past(coded, 6))
    else $error("pipeline latency wrong");
  ce_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !ce |=> ($stable(data_out) && $stable(data_oe) && $stable(data_valid) &&
     $stable(fifo_valid) && $stable(fifo_data) && $stable(fifo_overflow)))
    else $error("outputs moved with clock enable low");
  fifo_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && fifo_valid && !fifo_ready) |=> (fifo_valid && $stable(fifo_data)))
    else $error("buffered word dropped before it was taken");
  ovf_sticky_a: assert property (@(posedge clk) disable iff (sys_rst)
    fifo_overflow |=> fifo_overflow)
    else $error("overflow flag cleared without reset");
endmodule // pao_top
`default_nettype wire

// ---- testbench/pao_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pao_host_model
(
  input wire logic clk,
  input wire logic ce,
  input wire logic [1:0] mode,
  input wire logic fifo_valid,
  input wire logic [pao_pkg::SAMPLE_W-1:0] fifo_data,
  output logic fifo_ready,
  output logic took,
  output logic [pao_pkg::SAMPLE_W-1:0] took_data
);
  import pao_pkg::*;
  // Mode 0 prompt, 1 slow, 2 stalled
  initial
  begin
    fifo_ready = 1'b0;
    took = 1'b0;
    took_data = '0;
  end
  always @(posedge clk)
  begin
    // Only buffered words are taken, so words flagged invalid during the wake count never arrive
    took <= ce && fifo_valid && fifo_ready;
    took_data <= fifo_data;
    fifo_ready <= (mode == 2'h0) || (mode == 2'h1 && $urandom_range(1) == 1);
  end
endmodule // pao_host_model
`default_nettype wire

// ---- testbench/pipelined_adc_output_control_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) \
  begin \
    checks++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("ERROR t=%0t %s", $time, msg); \
    end \
  end
module pipelined_adc_output_control_test;
  import pao_pkg::*;
  logic clk, sys_rst, ce, output_enable_n, power_down;
  logic [SAMPLE_W-1:0] sample_twos, data_out, data_oe, fifo_data, took_data;
  logic data_valid, fifo_valid, fifo_ready, fifo_overflow, took;
  logic [1:0] mode;
  int mismatches = 0;
  int checks = 0;
  int k = -1;
  int popped = 0;
  int n;
  bit rnd_ce = 0;
  logic [SAMPLE_W-1:0] hist[$];
  logic [SAMPLE_W-1:0] fq[$];
  logic [SAMPLE_W-1:0] exp_oe = '0;
  logic [SAMPLE_W-1:0] marks[5] = '{10'h200, 10'h000, 10'h1ff, 10'h1fe, 10'h001};

  pao_top pao_top_inst (.clk(clk), .sys_rst(sys_rst), .ce(ce),
    .sample_twos(sample_twos), .output_enable_n(output_enable_n),
    .power_down(power_down), .data_out(data_out), .data_oe(data_oe),
    .data_valid(data_valid), .fifo_valid(fifo_valid),
    .fifo_data(fifo_data), .fifo_ready(fifo_ready),
    .fifo_overflow(fifo_overflow));
  pao_host_model pao_host_model_inst (.clk(clk), .ce(ce), .mode(mode),
    .fifo_valid(fifo_valid), .fifo_data(fifo_data),
    .fifo_ready(fifo_ready), .took(took), .took_data(took_data));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////
  // Reference model, advanced on the same edges as the design
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      k = -1;
      hist.delete();
      fq.delete();
      exp_oe = '0;
    end
    else if (ce)
    begin
      hist.push_back(sample_twos ^ SIGN_FLIP);
      if (hist.size() > 8)
        void'(hist.pop_front());
      exp_oe = (!output_enable_n && !power_down) ? '1 : '0;
      k = power_down ? -1 : (k < 0 ? 0 : (k < 9 ? k + 1 : k));
      if (k >= WAKE_CYCLES)
        fq.push_back(hist[hist.size() - 1 - LATENCY]);
    end
  end
  // Outputs are compared mid-cycle, where they have settled
  always @(negedge clk)
  begin
    if (!sys_rst)
    begin
      `CHK(data_oe, exp_oe, "driver enable")
      `CHK(data_valid, k >= WAKE_CYCLES, "valid flag")
      if (k >= WAKE_CYCLES)
        `CHK(data_out, hist[hist.size()-1-LATENCY], "word")
      if (took)
      begin
        popped++;
        `CHK(took_data, fq.pop_front(), "buffered word")
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic step(input int cnt);
    repeat (cnt)
    begin
      @(posedge clk);
      sample_twos <= SAMPLE_W'($urandom);
      if (rnd_ce)
        ce <= ($urandom_range(7) != 0);
    end
  endtask

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    #200000;
    mismatches++;
    end_sim();
  end

  initial
  begin
    void'($urandom(32'h09d5d91f));
    sys_rst = 1'b1;
    ce = 1'b1;
    output_enable_n = 1'b0;
    power_down = 1'b0;
    sample_twos = '0;
    mode = 2'h0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    step(30);
    for (int i = 0; i < 4; i++)
    begin
      output_enable_n <= i[0];
      power_down <= i[1];
      step(12);
    end
    output_enable_n <= 1'b0;
    power_down <= 1'b0;
    step(12);
    foreach (marks[j])
    begin
      @(posedge clk);
      sample_twos <= marks[j];
    end
    step(8);
    // Single-cycle power-down pulse in mid-stream
    power_down <= 1'b1;
    step(1);
    power_down <= 1'b0;
    step(12);
    // Slow sink with gaps in the clock enable; bursts kept short enough
    mode <= 2'h1;
    rnd_ce = 1;
    repeat (6)
    begin
      power_down <= 1'b0;
      step(10);
      power_down <= 1'b1;
      step(20);
    end
    rnd_ce = 0;
    ce <= 1'b1;
    @(negedge clk);
    `CHK(fifo_overflow, 1'b0, "no loss yet")
    // Stalled sink until words are lost, then drain to empty
    @(posedge clk);
    mode <= 2'h2;
    power_down <= 1'b0;
    step(30);
    power_down <= 1'b1;
    step(3);
    popped = 0;
    mode <= 2'h0;
    @(negedge clk);
    `CHK(fifo_overflow, 1'b1, "loss flagged")
    for (n = 0; n < 50 && fifo_valid !== 1'b0; n++)
      @(negedge clk);
    @(negedge clk);
    if (n == 50)
    begin
      mismatches++;
      end_sim();
    end
    `CHK(popped, FIFO_DEPTH + 1, "words kept")
    @(posedge clk);
    sys_rst <= 1'b1;
    step(2);
    sys_rst <= 1'b0;
    power_down <= 1'b0;
    @(negedge clk);
    `CHK(fifo_overflow, 1'b0, "flag cleared")
    step(30);
    end_sim();
  end
endmodule // pipelined_adc_output_control_test
`default_nettype wire
